// ===== hdl/flc_config_regs.sv
/*
 * Loop configuration registers with APB slave, reference selection and
 * pre-division, and decoded settings for the analog oscillator.
 * Assumes a zero-wait APB3 master on pclk and asynchronous reference pins.
 */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps

// Contract
// R1 - Fraction bit 0 gives integer mode, 1 gives fractional mode.
// R2 - Software sets oscillator enable before loop enable.
// R3 - Oscillator enable acts only in free-running mode, not when locked.
// R4 - Output clock is oscillator divided by code plus one, 4 to 64.
// R5 - Control block runs at oscillator divided by rate code plus one.
// R6 - Ratio divider codes give 1, 2, 4, 8, or 16 for 1XX.
// R7 - Sixteen-bit fraction, top bit one half, added to integer part.
// R8 - Ten-bit integer multiplier in bits 14 to 5, LSB weight one.
// R9 - Loop error gain is two to the power of the gain code.
// R10 - Reference predivided by 1, 2, 4 or 8 per the two-bit code.
// R11 - Software keeps the divided reference at or below 13.5 MHz.
// R12 - Source 00 master clock, 01 bit clock, 10 frame clock.
// R13 - Software programs all fields before enabling, then leaves them.
module flc_config_regs (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [flc_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mclk_pin,
	input wire logic bclk_pin,
	input wire logic lrclk_pin,
	output logic ref_tick,
	output flc_pkg::flc_osc_cfg_t osc_cfg
);

	logic [flc_pkg::REG_W-1:0] regs_q [flc_pkg::NUM_RW];
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic sel_ref_q;
	logic [2:0] slot;
	logic wr_en;
	logic tick_toggle_q;
	logic [flc_pkg::REG_W-1:0] status;
	logic [flc_pkg::REG_W-1:0] en_r;
	logic [flc_pkg::REG_W-1:0] dv_r;
	logic [flc_pkg::REG_W-1:0] fr_r;
	logic [flc_pkg::REG_W-1:0] mg_r;
	logic [flc_pkg::REG_W-1:0] rf_r;
	logic [5:0] outdiv;
	logic [2:0] ctrl_rate;
	logic [2:0] ratio;
	logic [9:0] int_mult;
	logic [3:0] gain;
	logic [1:0] ref_div;
	logic [1:0] ref_src;
	logic loop_en_q;
	logic frac_en_q;
	logic free_run_q;
	logic [6:0] out_div_q;
	logic [3:0] ctrl_rate_div_q;
	logic [4:0] ratio_div_q;
	logic [3:0] gain_shift_q;
	logic [flc_pkg::MULT_INT_W+flc_pkg::FRAC_W-1:0] multiplier_q;

	// Byte address to register slot; used by both read and write paths.
	function automatic logic [2:0] dec_slot(
		input logic [flc_pkg::ADDR_W-1:0] a
	);
		logic [2:0] s;
		s = flc_pkg::SLOT_NONE;
		if (a[1:0] == 2'h0) begin
			case (a[flc_pkg::ADDR_W-1:2])
				flc_pkg::IDX_ENABLE: s = 3'h0;
				flc_pkg::IDX_DIVIDER: s = 3'h1;
				flc_pkg::IDX_FRACTION: s = 3'h2;
				flc_pkg::IDX_MULT_GAIN: s = 3'h3;
				flc_pkg::IDX_REFERENCE: s = 3'h4;
				flc_pkg::IDX_STATUS: s = flc_pkg::SLOT_STATUS;
				default: s = flc_pkg::SLOT_NONE;
			endcase
		end
		return s;
	endfunction

	// Ratio code to divisor; all codes with the top bit set mean 16.
	function automatic logic [4:0] ratio_divisor(input logic [2:0] c);
		return c[2] ? 5'h10 : 5'(5'h01 << c[1:0]);
	endfunction

	// Field views of the stored registers.
	assign en_r = regs_q[0];
	assign dv_r = regs_q[1];
	assign fr_r = regs_q[2];
	assign mg_r = regs_q[3];
	assign rf_r = regs_q[4];
	assign outdiv = dv_r[flc_pkg::OUTDIV_LSB +: flc_pkg::OUTDIV_W];
	assign ctrl_rate = dv_r[flc_pkg::CTRL_RATE_LSB +: flc_pkg::CTRL_RATE_W];
	assign ratio = dv_r[flc_pkg::RATIO_LSB +: flc_pkg::RATIO_W];
	assign int_mult = mg_r[flc_pkg::MULT_INT_LSB +: flc_pkg::MULT_INT_W];
	assign gain = mg_r[flc_pkg::GAIN_LSB +: flc_pkg::GAIN_W];
	assign ref_div = rf_r[flc_pkg::REF_DIV_LSB +: 2];
	assign ref_src = rf_r[flc_pkg::REF_SRC_LSB +: 2];

	// Bus decode. The slave never stalls, so every access is two cycles.
	assign slot = dec_slot(paddr);
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite && (slot < 3'h5);

	// Status view: divided reference toggle and illegal-code flags.
	assign status = {13'h0000, (ref_src == 2'h3),
		(outdiv < flc_pkg::OUTDIV_FIRST_LEGAL), tick_toggle_q};

	// Read data and error are captured in the setup cycle so that both
	// come from flops; no write can land between setup and access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= (slot == flc_pkg::SLOT_NONE) ||
				(pwrite && slot == flc_pkg::SLOT_STATUS);
			if (pwrite || slot == flc_pkg::SLOT_NONE) begin
				prdata <= 32'h0000_0000;
			end else if (slot == flc_pkg::SLOT_STATUS) begin
				prdata <= {16'h0000, status};
			end else begin
				prdata <= {16'h0000, regs_q[slot]};
			end
		end
	end

	// Register storage; reserved bits are masked so they read as zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < flc_pkg::NUM_RW; i++) begin
				regs_q[i] <= flc_pkg::RESET_VAL[i];
			end
		end else if (wr_en) begin
			regs_q[slot] <= pwdata[flc_pkg::REG_W-1:0] &
				flc_pkg::WRITE_MASK[slot];
		end
	end

	// Reference pins cross into pclk through two flops each.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_q <= 3'h0;
			pin_s2_q <= 3'h0;
		end else begin
			pin_s1_q <= {lrclk_pin, bclk_pin, mclk_pin};
			pin_s2_q <= pin_s1_q;
		end
	end

	// Source mux after the synchronisers; the reserved code selects
	// nothing so the divider sees no edges rather than a stray pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_ref_q <= 1'b0;
		end else begin
			case (ref_src) // R12
				flc_pkg::SRC_MASTER: sel_ref_q <= pin_s2_q[0];
				flc_pkg::SRC_BIT: sel_ref_q <= pin_s2_q[1];
				flc_pkg::SRC_FRAME: sel_ref_q <= pin_s2_q[2];
				default: sel_ref_q <= 1'b0;
			endcase
		end
	end

	// Pre-divider runs only while the loop is enabled.
	flc_ref_divider u_ref_div (
		.pclk(pclk),
		.presetn(presetn),
		.run(en_r[flc_pkg::LOOP_ENABLE_BIT]),
		.ref_level(sel_ref_q),
		.reference_divider(ref_div), // R10
		.ref_tick(ref_tick)
	);

	// Toggle lets software see reference activity without a sticky flag.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_toggle_q <= 1'b0;
		end else if (ref_tick) begin
			tick_toggle_q <= ~tick_toggle_q;
		end
	end

	// Enable and mode bits to the oscillator. The software ordering of
	// oscillator and loop enables is not enforced here.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_en_q <= 1'b0;
			frac_en_q <= 1'b0;
			free_run_q <= 1'b0;
		end else begin
			loop_en_q <= en_r[flc_pkg::LOOP_ENABLE_BIT];
			frac_en_q <= en_r[flc_pkg::FRAC_MODE_BIT]; // R1
			free_run_q <= en_r[flc_pkg::OSC_ENABLE_BIT] &&
				!en_r[flc_pkg::LOOP_ENABLE_BIT]; // R3
		end
	end

	// Divisors. Reserved output codes still pass n+1; software must
	// avoid them and the status register flags them.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_div_q <= 7'h01;
			ctrl_rate_div_q <= 4'h1;
			ratio_div_q <= 5'h10;
		end else begin
			out_div_q <= {1'b0, outdiv} + 7'h01; // R4
			ctrl_rate_div_q <= {1'b0, ctrl_rate} + 4'h1; // R5
			ratio_div_q <= ratio_divisor(ratio); // R6
		end
	end

	// Multiplier as 10.16 fixed point; the fraction is dropped in integer
	// mode. Gain codes above x256 are undefined and clamp to x256.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			multiplier_q <= 26'h000_0000;
			gain_shift_q <= 4'h0;
		end else begin
			if (en_r[flc_pkg::FRAC_MODE_BIT]) begin // R1
				multiplier_q <= {int_mult, fr_r}; // R7 R8
			end else begin
				multiplier_q <= {int_mult, 16'h0000}; // R8
			end
			gain_shift_q <= (gain > flc_pkg::GAIN_MAX_CODE) ?
				flc_pkg::GAIN_MAX_CODE : gain; // R9
		end
	end

	// The bundle has a single driver; its fields live in separate flops
	// so each concern keeps its own process without sharing a variable.
	assign osc_cfg = '{
		loop_enable: loop_en_q,
		fractional_mode_enable: frac_en_q,
		osc_free_run: free_run_q,
		out_div: out_div_q,
		ctrl_rate_div: ctrl_rate_div_q,
		ratio_div: ratio_div_q,
		gain_shift: gain_shift_q,
		multiplier: multiplier_q
	};

	chk_integer_mode: assert property (@(posedge pclk) disable iff (!presetn) // R1
		!en_r[flc_pkg::FRAC_MODE_BIT] |=>
		osc_cfg.multiplier[15:0] == 16'h0000)
		else $error("fraction used in integer mode");

	chk_fraction_sum: assert property (@(posedge pclk) disable iff (!presetn) // R7
		en_r[flc_pkg::FRAC_MODE_BIT] |=>
		osc_cfg.multiplier == {$past(mg_r[14:5]), $past(fr_r)})
		else $error("multiplier not integer plus fraction");

	chk_output_div: assert property (@(posedge pclk) disable iff (!presetn) // R4
		(outdiv == 6'h3f) |=> osc_cfg.out_div == 7'h40)
		else $error("output divider code 63 not divide by 64");

	chk_ctrl_rate: assert property (@(posedge pclk) disable iff (!presetn) // R5
		1'b1 |=> osc_cfg.ctrl_rate_div == $past(dv_r[6:4]) + 3'h1)
		else $error("control rate divisor wrong");

	chk_ratio_top: assert property (@(posedge pclk) disable iff (!presetn) // R6
		dv_r[2] |=> osc_cfg.ratio_div == 5'h10)
		else $error("ratio 1XX not sixteen");

	chk_gain_value: assert property (@(posedge pclk) disable iff (!presetn) // R9
		(mg_r[3:0] <= 4'h8) |=> osc_cfg.gain_shift == $past(mg_r[3:0]))
		else $error("gain shift not equal to code");

	chk_osc_locked: assert property (@(posedge pclk) disable iff (!presetn) // R3
		en_r[0] |=> !osc_cfg.osc_free_run)
		else $error("free run asserted while loop enabled");

	chk_source_bit: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(ref_src == 2'h1) |=> sel_ref_q == $past(pin_s2_q[1]))
		else $error("bit clock source not selected");

	chk_source_none: assert property (@(posedge pclk) disable iff (!presetn) // R12
		(ref_src == 2'h3) |=> !sel_ref_q)
		else $error("reserved source passes a reference");

	chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && slot == flc_pkg::SLOT_NONE) |=>
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	chk_write_stored: assert property (@(posedge pclk) disable iff (!presetn) // R8
		(wr_en && slot == 3'h3) |=>
		mg_r == ($past(pwdata[15:0]) & flc_pkg::WRITE_MASK[3]))
		else $error("written multiplier word not stored");

	cov_frac_enable: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(en_r[flc_pkg::FRAC_MODE_BIT]) ##1 en_r[0]);

	cov_ref_ticks: cover property (@(posedge pclk) disable iff (!presetn)
		ref_tick ##[1:50] ref_tick);

	cov_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pslverr);

endmodule

// ===== shared/flc_pkg.sv
/*
 * Shared constants and types for the loop configuration block: register
 * indices and byte addresses, field positions, reset values, write masks
 * and the settings bundle handed to the analog oscillator.
 * Assumes a 32-bit APB with byte addresses; each register is one word.
 */
package flc_pkg;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_ENABLE = 10'h074;
	localparam logic [9:0] IDX_DIVIDER = 10'h075;
	localparam logic [9:0] IDX_FRACTION = 10'h076;
	localparam logic [9:0] IDX_MULT_GAIN = 10'h077;
	localparam logic [9:0] IDX_REFERENCE = 10'h078;
	localparam logic [9:0] IDX_STATUS = 10'h080;
	localparam int ADDR_W = 12;
	localparam int NUM_RW = 5;
	localparam int REG_W = 16;
	localparam logic [2:0] SLOT_STATUS = 3'h5;
	localparam logic [2:0] SLOT_NONE = 3'h7;

	// Field positions.
	localparam int LOOP_ENABLE_BIT = 0;
	localparam int OSC_ENABLE_BIT = 1;
	localparam int FRAC_MODE_BIT = 2;
	localparam int OUTDIV_LSB = 8;
	localparam int OUTDIV_W = 6;
	localparam int CTRL_RATE_LSB = 4;
	localparam int CTRL_RATE_W = 3;
	localparam int RATIO_LSB = 0;
	localparam int RATIO_W = 3;
	localparam int MULT_INT_LSB = 5;
	localparam int MULT_INT_W = 10;
	localparam int FRAC_W = 16;
	localparam int GAIN_LSB = 0;
	localparam int GAIN_W = 4;
	localparam int REF_DIV_LSB = 3;
	localparam int REF_SRC_LSB = 0;

	// Codes and limits.
	localparam logic [5:0] OUTDIV_FIRST_LEGAL = 6'h03;
	localparam logic [3:0] GAIN_MAX_CODE = 4'h8;
	localparam logic [1:0] SRC_MASTER = 2'h0;
	localparam logic [1:0] SRC_BIT = 2'h1;
	localparam logic [1:0] SRC_FRAME = 2'h2;

	// Reset values and writable bits, slot order enable..reference.
	localparam logic [NUM_RW-1:0][REG_W-1:0] RESET_VAL = {
		16'h0000, 16'h2EE0, 16'h0000, 16'h0007, 16'h0000};
	localparam logic [NUM_RW-1:0][REG_W-1:0] WRITE_MASK = {
		16'h001B, 16'h7FEF, 16'hFFFF, 16'h3F77, 16'h0007};

	// Settings driven to the analog oscillator.
	typedef struct packed {
		logic loop_enable;
		logic fractional_mode_enable;
		logic osc_free_run;
		logic [6:0] out_div;
		logic [3:0] ctrl_rate_div;
		logic [4:0] ratio_div;
		logic [3:0] gain_shift;
		logic [MULT_INT_W+FRAC_W-1:0] multiplier;
	} flc_osc_cfg_t;

endpackage

// ===== hdl/flc_ref_divider.sv
/*
 * Reference pre-divider: counts rising edges of the selected, already
 * synchronised reference level and pulses once per 1, 2, 4 or 8 edges.
 * Assumes the level is in the pclk domain and slower than pclk / 2.
 */
`timescale 1ns/100ps
module flc_ref_divider (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic ref_level,
	input wire logic [1:0] reference_divider,
	output logic ref_tick
);

	logic level_q;
	logic [2:0] edge_cnt_q;
	logic rise;
	logic [2:0] last_edge;

	assign rise = ref_level & ~level_q;
	assign last_edge = 3'((4'h1 << reference_divider) - 4'h1);

	// Previous level for edge detection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= 1'b0;
		end else begin
			level_q <= ref_level;
		end
	end

	// Edge counter; held cleared while the loop is off so a fresh start
	// always begins a full divided period.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_cnt_q <= 3'h0;
			ref_tick <= 1'b0;
		end else if (!run) begin
			edge_cnt_q <= 3'h0;
			ref_tick <= 1'b0;
		end else begin
			ref_tick <= rise && (edge_cnt_q >= last_edge); // R10
			if (rise) begin
				edge_cnt_q <= (edge_cnt_q >= last_edge) ? 3'h0 :
					edge_cnt_q + 3'h1;
			end
		end
	end

	chk_div_one_tick: assert property (@(posedge pclk) disable iff (!presetn) // R10
		(run && rise && reference_divider == 2'h0) |=> ref_tick)
		else $error("divide by one missed a reference edge");

	chk_tick_cause: assert property (@(posedge pclk) disable iff (!presetn) // R10
		ref_tick |-> $past(rise) && $past(run))
		else $error("reference tick without an edge");

	cov_div_eight: cover property (@(posedge pclk) disable iff (!presetn)
		reference_divider == 2'h3 && ref_tick);

endmodule

// ===== verification/flc_ref_pins.sv
/*
 * Reference pin model: three free-running clocks standing in for the
 * master, bit and frame clock pins, each toggling every HALFn cycles.
 * Assumes it is clocked by pclk and reset with the block under test.
 */
`timescale 1ns/100ps
module flc_ref_pins #(
	parameter int HALF0 = 8,
	parameter int HALF1 = 10,
	parameter int HALF2 = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic [2:0] pins
);
	localparam int HALF[3] = '{HALF0, HALF1, HALF2};
	int cnt_q[3];

	// Each pin stays high and low for at least two cycles, and every rate
	// is kept below 13.5 MHz so that any divider code stays legal.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '{default: 0};
			pins <= 3'h0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				if (cnt_q[k] == HALF[k] - 1) begin
					cnt_q[k] <= 0;
					pins[k] <= ~pins[k];
				end else begin
					cnt_q[k] <= cnt_q[k] + 1;
				end
			end
		end
	end
endmodule

// ===== verification/flc_config_regs_tb.sv
/*
 * Self-checking bench for the loop configuration block: reset values,
 * access kinds, field decoding and reference selection and division.
 * Assumes the reference pin model and a 200 MHz pclk.
 */
`timescale 1ns/100ps
module flc_config_regs_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ref_tick;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] pins;
	flc_pkg::flc_osc_cfg_t osc_cfg;
	int miscompares, checks;
	localparam int HALF[3] = '{8, 10, 12};
	localparam logic [11:0] A_EN = {flc_pkg::IDX_ENABLE, 2'b00};
	localparam logic [11:0] A_DIV = {flc_pkg::IDX_DIVIDER, 2'b00};
	localparam logic [11:0] A_FRAC = {flc_pkg::IDX_FRACTION, 2'b00};
	localparam logic [11:0] A_MG = {flc_pkg::IDX_MULT_GAIN, 2'b00};
	localparam logic [11:0] A_REF = {flc_pkg::IDX_REFERENCE, 2'b00};
	localparam logic [15:0] RST[5] = '{16'h0000, 16'h0007, 16'h0000,
		16'h2EE0, 16'h0000};
	localparam logic [15:0] MASK[5] = '{16'h0007, 16'h3F77, 16'hFFFF,
		16'h7FEF, 16'h001B};

	flc_config_regs flc_config_regs_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mclk_pin(pins[0]), .bclk_pin(pins[1]),
		.lrclk_pin(pins[2]), .ref_tick(ref_tick), .osc_cfg(osc_cfg));
	flc_ref_pins #(.HALF0(8), .HALF1(10), .HALF2(12)) flc_ref_pins_i (
		.pclk(pclk), .presetn(presetn), .pins(pins));

	// Free-running 200 MHz clock.
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen high.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1, a, d, r, e);
	endtask

	// Lets the register update reach the oscillator settings.
	task automatic settle;
		repeat (2) @(posedge pclk);
		#1;
	endtask

	task automatic t_reset;
		logic [31:0] r;
		logic e;
		check(32'(osc_cfg.out_div), 32'h1);
		check(32'(osc_cfg.ctrl_rate_div), 32'h1);
		check(32'(osc_cfg.ratio_div), 32'h10);
		check(32'(osc_cfg.gain_shift), 32'h0);
		check(32'(osc_cfg.multiplier), {6'h0, 10'h177, 16'h0});
		check(32'(osc_cfg.loop_enable), 32'h0);
		for (int i = 0; i < 5; i++) begin
			apb(0, A_EN + 12'(4 * i), 32'h0, r, e);
			check(r, {16'h0, RST[i]});
		end
		$display("t_reset done");
	endtask

	// Every writable bit set, unmapped and misaligned places refused.
	task automatic t_access;
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 5; i++) begin
			wr(A_EN + 12'(4 * i), 32'hFFFF_FFFF);
			apb(0, A_EN + 12'(4 * i), 32'h0, r, e);
			check(r, {16'h0, MASK[i]});
			wr(A_EN + 12'(4 * i), {16'h0, RST[i]});
		end
		apb(0, 12'h1E4, 32'h0, r, e);
		check({r[30:0], e}, 32'h1);
		apb(0, 12'h1D2, 32'h0, r, e);
		check({r[30:0], e}, 32'h1);
		apb(1, 12'h200, 32'hFFFF, r, e);
		check(32'(e), 32'h1);
		apb(0, 12'h200, 32'h0, r, e);
		check({r[31:1], e}, 32'h2);
		$display("t_access done");
	endtask

	task automatic t_divider;
		logic [5:0] code;
		for (int i = 0; i < 8; i++) begin
			code = (i < 7) ? 6'(3 + 9 * i) : 6'h3F;
			wr(A_DIV, {18'h0, code, 1'b0, 3'(i), 1'b0, 3'(i)});
			settle;
			check(32'(osc_cfg.out_div), 32'(code) + 1);
			check(32'(osc_cfg.ctrl_rate_div), 32'(i + 1));
			check(32'(osc_cfg.ratio_div), (i > 3) ? 16 : (1 << i));
		end
		wr(A_DIV, 32'h0007);
		$display("t_divider done");
	endtask

	task automatic t_gain_mult;
		logic [9:0] n;
		for (int g = 0; g < 16; g++) begin
			n = 10'h155 ^ 10'(g * 37);
			wr(A_MG, {17'h0, n, 1'b0, 4'(g)});
			settle;
			check(32'(osc_cfg.gain_shift), (g > 8) ? 8 : g);
			check(32'(osc_cfg.multiplier[25:16]), 32'(n));
		end
		wr(A_FRAC, 32'h8001);
		settle;
		check(32'(osc_cfg.multiplier[15:0]), 32'h0);
		wr(A_EN, 32'h4);
		settle;
		check(32'(osc_cfg.fractional_mode_enable), 32'h1);
		check(32'(osc_cfg.multiplier), {6'h0, n, 16'h8001});
		wr(A_EN, 32'h0);
		wr(A_FRAC, 32'h0);
		$display("t_gain_mult done");
	endtask

	// Oscillator enable acts alone only while the loop is not running.
	task automatic t_enable;
		wr(A_EN, 32'h2);
		settle;
		check(32'({osc_cfg.osc_free_run, osc_cfg.loop_enable}), 32'h2);
		wr(A_EN, 32'h3);
		settle;
		check(32'({osc_cfg.osc_free_run, osc_cfg.loop_enable}), 32'h1);
		wr(A_EN, 32'h0);
		settle;
		check(32'({osc_cfg.osc_free_run, osc_cfg.loop_enable}), 32'h0);
		$display("t_enable done");
	endtask

	task automatic wait_tick(output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (ref_tick !== 1'b1 && n < 2000);
	endtask

	task automatic count_ticks(output int n);
		n = 0;
		repeat (300) begin
			@(posedge pclk);
			if (ref_tick === 1'b1)
				n++;
		end
	endtask

	// Tick spacing is the pin period times the divider; the first tick
	// after enabling may come early, so it is discarded.
	task automatic t_reference;
		logic [31:0] r;
		logic e;
		int n;
		for (int k = 0; k < 4; k++) begin
			wr(A_REF, 32'((k << 3) | (k % 3)));
			wr(A_EN, 32'h2);
			wr(A_EN, 32'h3);
			wait_tick(n);
			wait_tick(n);
			check(32'(n), 32'((2 * HALF[k % 3]) << k));
			wr(A_EN, 32'h0);
		end
		wr(A_REF, 32'h3);
		apb(0, 12'h200, 32'h0, r, e);
		check(32'(r[2:1]), 32'h3);
		wr(A_EN, 32'h2);
		wr(A_EN, 32'h3);
		count_ticks(n);
		check(32'(n), 32'h0);
		wr(A_EN, 32'h0);
		wr(A_REF, 32'h0);
		count_ticks(n);
		check(32'(n), 32'h0);
		$display("t_reference done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0;
		miscompares = 0;
		checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
		settle;
		t_reset;
		t_access;
		t_divider;
		t_gain_mult;
		t_enable;
		t_reference;
		tally_and_finish;
	end

	// The run needs under two thousand cycles; this bound catches a hang.
	initial begin
		repeat (40000) @(posedge pclk);
		miscompares++;
		tally_and_finish;
	end
endmodule
